// ===== src/spc_pkg.sv
/*
 * Package for the sleep and power controller: register map, field
 * positions, reset values, modes and timing counts.
 * Assumes a 125 MHz system clock and an APB slave with 32-bit data.
 */
package spc_pkg;

    localparam int unsigned CLK_MHZ          = 125;

    // Register byte addresses
    localparam logic [11:0] ADDR_CORE_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_CLK_STOP    = 12'h004;
    localparam logic [11:0] ADDR_STATUS      = 12'h008;
    localparam logic [11:0] ADDR_WAKE_CFG    = 12'h00C;

    // Core control register fields
    localparam int unsigned BIT_BOD_OFF      = 7;
    localparam int unsigned BIT_PULLUP_OFF   = 6;
    localparam int unsigned BIT_SLEEP_ARM    = 5;
    localparam int unsigned BIT_MODE_HI      = 4;
    localparam int unsigned BIT_MODE_LO      = 3;
    localparam int unsigned BIT_BOD_UNLOCK   = 2;
    localparam logic [7:0]  CORE_CTRL_RESET  = 8'h00;

    // Module clock stop register: bits 3:0 writable, bits 7:4 reserved
    localparam int unsigned NUM_GATED        = 4;
    localparam logic [7:0]  CLK_STOP_WMASK   = 8'h0F;
    localparam logic [7:0]  CLK_STOP_RESET   = 8'h00;
    localparam int unsigned GATE_ADC         = 0;

    // Wake configuration: bit 0 set means external interrupt zero is level sensed
    localparam int unsigned BIT_EXT0_LEVEL   = 0;

    // Timed sequence windows, in clock cycles
    localparam logic [2:0]  UNLOCK_CYCLES    = 3'h4;
    localparam logic [2:0]  BOD_OFF_DELAY    = 3'h3;
    localparam logic [2:0]  BOD_OFF_HOLD     = 3'h3;

    // Extra halt after oscillator start-up, in cycles
    localparam logic [3:0]  WAKE_HALT_CYCLES = 4'h4;

    // Oscillator start-up and reset-equivalent wake delays
    localparam int unsigned OSC_START_NS     = 1000;
    localparam int unsigned RESET_WAKE_NS    = 4100000;
    localparam int unsigned OSC_START_CYC    = (OSC_START_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RESET_WAKE_CYC   = (RESET_WAKE_NS / 1000) * CLK_MHZ;

    localparam logic [1:0]  MODE_IDLE        = 2'h0;
    localparam logic [1:0]  MODE_ADC_NR      = 2'h1;
    localparam logic [1:0]  MODE_PWR_DOWN    = 2'h2;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_IDLE,
        ST_ADC_NR,
        ST_PWR_DOWN,
        ST_OSC_START,
        ST_HALT
    } spc_state_t;

endpackage

// ===== src/spc_sleep_ctrl.sv
/*
 * Sleep and power controller: sleep entry, clock domain gating,
 * wake-up qualification and halt timing, brown-out sleep disable,
 * per-module clock stop and input buffer disable.
 * Assumes the CPU pulses sleepInstr for one cycle, interrupt sources
 * arrive as synchronous levels and the register file/SRAM are
 * retained simply by this block never resetting them.
 */
// Behaviour
// R1: Sleep needs arm bit plus sleep instruction
// R2: Mode 00 idle stops CPU, flash clocks
// R3: Mode 01 also stops the I/O clock
// R4: Mode 10 stops oscillator and all clocks
// R5: Wake halts four cycles after oscillator start
// R6: Reset during sleep restarts at reset vector
// R7: Registers and SRAM kept through sleep
// R8: Idle wakes on any enabled interrupt
// R9: ADC noise mode wakes on listed sources
// R10: Power-down wakes on resets, level zero, pinchange
// R11: Interrupt zero wakes deep modes only level-sensed
// R12: Idle or noise mode starts ADC conversion
// R13: Bit 7 sleep-off disables detector in power-down
// R14: Detector off at entry, on at wake
// R15: Detector-off wake uses reset delay
// R16: Sleep-off bit written only via unlock sequence
// R17: Set both, then within four cycles confirm
// R18: Bit live after three, clears after three
// R19: Clock-stop bit freezes module, blocks access
// R20: Clearing clock-stop bit resumes module state
// R21: Clock stop applies in active and idle
// R22: ADC stays enabled; re-enable means extended conversion
// R23: Comparator off in deeper modes unless reference
// R24: Input buffers off when I/O, ADC clocks stop
// R25: Reserved mode code 11 does not sleep
`timescale 1ns/1ns
`default_nettype none

module spc_sleep_ctrl
    import spc_pkg::*;
#(
    parameter int unsigned OSC_START  = OSC_START_CYC,
    parameter int unsigned RESET_WAKE = RESET_WAKE_CYC
)
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 clkEn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 sleepInstr,
    input  wire logic                 irqPending,
    input  wire logic                 irqPinChange,
    input  wire logic                 irqExtZero,
    input  wire logic                 irqMemReady,
    input  wire logic                 irqAdcDone,
    input  wire logic                 irqWatchdog,
    input  wire logic                 sleepReset,
    input  wire logic                 adcEnabled,
    input  wire logic                 compUsesRef,
    output logic                      cpuClkRun,
    output logic                      flashClkRun,
    output logic                      ioClkRun,
    output logic                      adcClkRun,
    output logic                      oscRun,
    output logic                      cpuHalt,
    output logic                      wakeToReset,
    output logic                      adcStartConv,
    output logic                      adcExtendedConv,
    output logic                      bodEnable,
    output logic                      compDisable,
    output logic                      inBufEnable,
    output logic [NUM_GATED-1:0]      moduleClkRun,
    output logic [NUM_GATED-1:0]      moduleAccessOk
);

    typedef struct packed {
        spc_state_t                  state;
        logic [7:0]                  coreCtrl;
        logic [7:0]                  clkStop;
        logic [7:0]                  wakeCfg;
        logic [2:0]                  unlockCnt;
        logic [2:0]                  bodDelayCnt;
        logic [2:0]                  bodHoldCnt;
        logic                        bodLive;
        logic                        bodOffSleep;
        logic [23:0]                 waitCnt;
        logic                        adcWasOn;
        logic                        extConvPend;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        logic                        cpuClkRun;
        logic                        flashClkRun;
        logic                        ioClkRun;
        logic                        adcClkRun;
        logic                        oscRun;
        logic                        cpuHalt;
        logic                        wakeToReset;
        logic                        adcStartConv;
        logic                        adcExtendedConv;
        logic                        bodEnable;
        logic                        compDisable;
        logic                        inBufEnable;
        logic [NUM_GATED-1:0]        moduleClkRun;
        logic [NUM_GATED-1:0]        moduleAccessOk;
    } spc_regs_t;

    spc_regs_t r_q;
    spc_regs_t r_d;

    logic        access;
    logic        wrEn;
    logic        wakeReq;
    logic        sleeping;
    logic [7:0]  wv;
    logic [1:0]  mode;
    logic        extZeroWake;

    assign access      = psel && penable;
    assign wrEn        = access && pwrite && !r_q.pready;
    assign wv          = pwdata[7:0];
    assign mode        = r_q.coreCtrl[BIT_MODE_HI:BIT_MODE_LO];
    assign sleeping    = (r_q.state == ST_IDLE) || (r_q.state == ST_ADC_NR)
                      || (r_q.state == ST_PWR_DOWN);
    // Edge-sensed interrupt zero cannot wake deep modes (no clock to sample edge)
    assign extZeroWake = irqExtZero && r_q.wakeCfg[BIT_EXT0_LEVEL]; // R11

    always_comb
    begin
        unique case (r_q.state)
            ST_IDLE:     wakeReq = irqPending || irqPinChange || irqExtZero
                                || irqMemReady || irqAdcDone || irqWatchdog; // R8
            ST_ADC_NR:   wakeReq = irqAdcDone || irqMemReady || extZeroWake
                                || irqPinChange || irqWatchdog; // R9
            ST_PWR_DOWN: wakeReq = extZeroWake || irqPinChange || irqWatchdog; // R10
            default:     wakeReq = 1'b0;
        endcase
    end

    always_comb
    begin
        r_d = r_q;
        r_d.pready       = 1'b0;
        r_d.pslverr      = 1'b0;
        r_d.adcStartConv = 1'b0;
        r_d.wakeToReset  = 1'b0;

        // APB: one wait state, answer in the cycle after the access phase starts
        if (access && !r_q.pready)
        begin
            r_d.pready = 1'b1;
            r_d.prdata = 32'h0000_0000;
            unique case (paddr)
                ADDR_CORE_CTRL: r_d.prdata[7:0] = r_q.coreCtrl;
                ADDR_CLK_STOP:  r_d.prdata[7:0] = r_q.clkStop;
                ADDR_STATUS:    r_d.prdata[7:0] = {4'h0, r_q.bodLive, r_q.state};
                ADDR_WAKE_CFG:  r_d.prdata[7:0] = r_q.wakeCfg;
                default:        r_d.pslverr = 1'b1;
            endcase
        end

        // Unlock window runs down each cycle
        if (r_q.unlockCnt != 3'h0)
        begin
            r_d.unlockCnt = r_q.unlockCnt - 3'h1; // R17
        end

        // Sleep-off bit: delayed activation, then self-clear
        if (r_q.bodDelayCnt != 3'h0)
        begin
            r_d.bodDelayCnt = r_q.bodDelayCnt - 3'h1;
            if (r_q.bodDelayCnt == 3'h1)
            begin
                r_d.bodLive    = 1'b1; // R18
                r_d.bodHoldCnt = BOD_OFF_HOLD;
            end
        end
        else if (r_q.bodHoldCnt != 3'h0)
        begin
            r_d.bodHoldCnt = r_q.bodHoldCnt - 3'h1;
            if (r_q.bodHoldCnt == 3'h1)
            begin
                r_d.bodLive                  = 1'b0; // R18
                r_d.coreCtrl[BIT_BOD_OFF]    = 1'b0;
            end
        end

        if (wrEn)
        begin
            unique case (paddr)
                ADDR_CORE_CTRL:
                begin
                    r_d.coreCtrl[6:3] = wv[6:3];
                    r_d.coreCtrl[1:0] = wv[1:0];
                    r_d.coreCtrl[BIT_BOD_UNLOCK] = wv[BIT_BOD_UNLOCK];
                    if (wv[BIT_BOD_OFF] && wv[BIT_BOD_UNLOCK])
                    begin
                        r_d.unlockCnt = UNLOCK_CYCLES; // R16
                    end
                    else if (wv[BIT_BOD_OFF] && r_q.unlockCnt != 3'h0)
                    begin
                        r_d.coreCtrl[BIT_BOD_OFF] = 1'b1; // R17
                        r_d.unlockCnt   = 3'h0;
                        r_d.bodDelayCnt = BOD_OFF_DELAY;
                    end
                end
                ADDR_CLK_STOP:
                    r_d.clkStop = wv & CLK_STOP_WMASK;
                ADDR_WAKE_CFG:
                    r_d.wakeCfg = {7'h00, wv[BIT_EXT0_LEVEL]};
                default:
                    ;
            endcase
        end

        unique case (r_q.state)
            ST_ACTIVE:
                if (sleepInstr && r_q.coreCtrl[BIT_SLEEP_ARM]) // R1
                begin
                    // Gated, never reset: CPU registers and SRAM keep their contents
                    r_d.cpuClkRun   = 1'b0; // R7
                    r_d.flashClkRun = 1'b0;
                    unique case (mode)
                        MODE_IDLE:
                        begin
                            r_d.state        = ST_IDLE; // R2
                            r_d.adcStartConv = adcEnabled; // R12
                        end
                        MODE_ADC_NR:
                        begin
                            r_d.state        = ST_ADC_NR; // R3
                            r_d.ioClkRun     = 1'b0;
                            r_d.adcStartConv = adcEnabled; // R12
                            r_d.inBufEnable  = 1'b1;
                        end
                        MODE_PWR_DOWN:
                        begin
                            r_d.state       = ST_PWR_DOWN; // R4
                            r_d.ioClkRun    = 1'b0;
                            r_d.adcClkRun   = 1'b0;
                            r_d.oscRun      = 1'b0;
                            r_d.inBufEnable = 1'b0; // R24
                            r_d.compDisable = !compUsesRef; // R23
                            r_d.bodOffSleep = r_q.bodLive; // R13
                            r_d.bodEnable   = !r_q.bodLive; // R14
                        end
                        default:
                        begin
                            r_d.cpuClkRun   = 1'b1; // R25
                            r_d.flashClkRun = 1'b1;
                        end
                    endcase
                end
            ST_IDLE, ST_ADC_NR, ST_PWR_DOWN:
                if (wakeReq)
                begin
                    r_d.state       = ST_OSC_START;
                    r_d.oscRun      = 1'b1;
                    r_d.bodEnable   = 1'b1; // R14
                    // Detector needs the full reset delay to settle
                    r_d.waitCnt     = r_q.bodOffSleep ? 24'(RESET_WAKE) : 24'(OSC_START); // R15
                end
            ST_OSC_START:
                if (r_q.waitCnt <= 24'h1)
                begin
                    r_d.state       = ST_HALT;
                    r_d.waitCnt     = 24'(WAKE_HALT_CYCLES); // R5
                    r_d.ioClkRun    = 1'b1;
                    r_d.adcClkRun   = 1'b1;
                    r_d.inBufEnable = 1'b1;
                    r_d.compDisable = 1'b0;
                end
                else
                begin
                    r_d.waitCnt = r_q.waitCnt - 24'h1;
                end
            ST_HALT:
                if (r_q.waitCnt <= 24'h1)
                begin
                    r_d.state       = ST_ACTIVE; // R5
                    r_d.cpuHalt     = 1'b0;
                    r_d.cpuClkRun   = 1'b1;
                    r_d.flashClkRun = 1'b1;
                    r_d.bodOffSleep = 1'b0;
                end
                else
                begin
                    r_d.waitCnt = r_q.waitCnt - 24'h1;
                end
        endcase

        if (r_d.state != ST_ACTIVE)
        begin
            r_d.cpuHalt = 1'b1;
        end

        // A reset while asleep wakes straight to the reset vector
        if (sleepReset && sleeping)
        begin
            r_d.state       = ST_ACTIVE; // R6
            r_d.wakeToReset = 1'b1;
            r_d.cpuHalt     = 1'b0;
            r_d.cpuClkRun   = 1'b1;
            r_d.flashClkRun = 1'b1;
            r_d.ioClkRun    = 1'b1;
            r_d.adcClkRun   = 1'b1;
            r_d.oscRun      = 1'b1;
            r_d.bodEnable   = 1'b1;
            r_d.inBufEnable = 1'b1;
            r_d.compDisable = 1'b0;
            r_d.bodOffSleep = 1'b0;
        end

        // ADC enable untouched by sleep; a fresh enable forces a long conversion
        r_d.adcWasOn = adcEnabled; // R22
        if (adcEnabled && !r_q.adcWasOn)
        begin
            r_d.extConvPend = 1'b1;
        end
        else if (r_q.adcStartConv)
        begin
            r_d.extConvPend = 1'b0;
        end
        r_d.adcExtendedConv = r_d.extConvPend;

        // Module gates: clock stop gates a clock only where its domain still runs, and always blocks access
        for (int g = 0; g < NUM_GATED; g++)
        begin
            r_d.moduleClkRun[g]   = ((g == GATE_ADC) ? r_d.adcClkRun : r_d.ioClkRun)
                                 && !r_d.clkStop[g]; // R19 R20 R21
            r_d.moduleAccessOk[g] = !r_d.clkStop[g]; // R19
        end
    end

    // Sleep state holds no copy of CPU registers or SRAM: they simply keep clock-gated
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            r_q.state           <= ST_ACTIVE;
            r_q.coreCtrl        <= CORE_CTRL_RESET;
            r_q.clkStop         <= CLK_STOP_RESET;
            r_q.wakeCfg         <= 8'h00;
            r_q.unlockCnt       <= 3'h0;
            r_q.bodDelayCnt     <= 3'h0;
            r_q.bodHoldCnt      <= 3'h0;
            r_q.bodLive         <= 1'b0;
            r_q.bodOffSleep     <= 1'b0;
            r_q.waitCnt         <= 24'h0;
            r_q.adcWasOn        <= 1'b0;
            r_q.extConvPend     <= 1'b0;
            r_q.prdata          <= 32'h0000_0000;
            r_q.pready          <= 1'b0;
            r_q.pslverr         <= 1'b0;
            r_q.cpuClkRun       <= 1'b1;
            r_q.flashClkRun     <= 1'b1;
            r_q.ioClkRun        <= 1'b1;
            r_q.adcClkRun       <= 1'b1;
            r_q.oscRun          <= 1'b1;
            r_q.cpuHalt         <= 1'b0;
            r_q.wakeToReset     <= 1'b0;
            r_q.adcStartConv    <= 1'b0;
            r_q.adcExtendedConv <= 1'b0;
            r_q.bodEnable       <= 1'b1;
            r_q.compDisable     <= 1'b0;
            r_q.inBufEnable     <= 1'b1;
            r_q.moduleClkRun    <= {NUM_GATED{1'b1}};
            r_q.moduleAccessOk  <= {NUM_GATED{1'b1}};
        end
        else if (clkEn)
        begin
            r_q <= r_d;
        end
    end

    assign prdata          = r_q.prdata;
    assign pready          = r_q.pready;
    assign pslverr         = r_q.pslverr;
    assign cpuClkRun       = r_q.cpuClkRun;
    assign flashClkRun     = r_q.flashClkRun;
    assign ioClkRun        = r_q.ioClkRun;
    assign adcClkRun       = r_q.adcClkRun;
    assign oscRun          = r_q.oscRun;
    assign cpuHalt         = r_q.cpuHalt;
    assign wakeToReset     = r_q.wakeToReset;
    assign adcStartConv    = r_q.adcStartConv;
    assign adcExtendedConv = r_q.adcExtendedConv;
    assign bodEnable       = r_q.bodEnable;
    assign compDisable     = r_q.compDisable;
    assign inBufEnable     = r_q.inBufEnable;
    assign moduleClkRun    = r_q.moduleClkRun;
    assign moduleAccessOk  = r_q.moduleAccessOk;

endmodule

`default_nettype wire

// ===== tb/spc_sleep_ctrl_asserts.sv
/* Port-level checks for spc_sleep_ctrl.
   Bound by name from the bench; clkEn low or reset pauses them. */
`timescale 1ns/1ns
`default_nettype none
module spc_sleep_ctrl_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic sleepInstr,
    input wire logic sleepReset,
    input wire logic adcEnabled,
    input wire logic compUsesRef,
    input wire logic cpuClkRun,
    input wire logic flashClkRun,
    input wire logic ioClkRun,
    input wire logic adcClkRun,
    input wire logic oscRun,
    input wire logic cpuHalt,
    input wire logic wakeToReset,
    input wire logic adcStartConv,
    input wire logic bodEnable,
    input wire logic compDisable,
    input wire logic inBufEnable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst || !clkEn);
    property p_arm; $rose(cpuHalt) |-> $past(sleepInstr); endproperty
    a_arm: assert property (p_arm) else $error("halt without sleep");
    property p_cpu; !cpuClkRun |-> !flashClkRun && cpuHalt; endproperty
    a_cpu: assert property (p_cpu) else $error("cpu clock stop");
    property p_lite; $rose(cpuHalt) && oscRun |-> !cpuClkRun && adcClkRun; endproperty
    a_lite: assert property (p_lite) else $error("light sleep clocks");
    property p_deep; !oscRun |-> !(cpuClkRun || flashClkRun || ioClkRun || adcClkRun); endproperty
    a_deep: assert property (p_deep) else $error("clock without osc");
    property p_halt; $rose(ioClkRun) && cpuHalt |-> cpuHalt[*4] ##1 !cpuHalt; endproperty
    a_halt: assert property (p_halt) else $error("wake halt length");
    property p_rst; wakeToReset |-> $past(sleepReset) && oscRun && !cpuHalt; endproperty
    a_rst: assert property (p_rst) else $error("reset wake");
    property p_conv; $rose(cpuHalt) |-> adcStartConv == ($past(adcEnabled) && adcClkRun); endproperty
    a_conv: assert property (p_conv) else $error("conversion start");
    property p_bodoff; $fell(bodEnable) |-> $fell(oscRun); endproperty
    a_bodoff: assert property (p_bodoff) else $error("detector off");
    property p_bodon; $rose(oscRun) |-> bodEnable; endproperty
    a_bodon: assert property (p_bodon) else $error("detector on");
    property p_comp; $fell(oscRun) |-> compDisable == !$past(compUsesRef); endproperty
    a_comp: assert property (p_comp) else $error("comparator off");
    property p_inbuf; $fell(oscRun) |-> !inBufEnable; endproperty
    a_inbuf: assert property (p_inbuf) else $error("input buffers");
endmodule
`default_nettype wire

// ===== tb/spc_cpu_model.sv
/* CPU and interrupt side: sleep pulse and held interrupt levels.
   Levels stay up until the core leaves halt, as a real source would. */
`timescale 1ns/1ns
`default_nettype none
module spc_cpu_model (
    input  wire logic       clk,
    input  wire logic       doSleep,
    input  wire logic [5:0] wakeSel,
    input  wire logic       cpuHalt,
    output logic            sleepInstr,
    output logic      [5:0] irq
);
    initial
    begin
        sleepInstr = 1'b0;
        irq = 6'h00;
    end
    always @(posedge clk)
    begin
        sleepInstr <= doSleep;
        irq <= cpuHalt ? (irq | wakeSel) : 6'h00;
    end
endmodule
`default_nettype wire

// ===== tb/spc_sleep_ctrl_test.sv
/* Bench for spc_sleep_ctrl: APB tasks, sleep and wake sequences.
   Short oscillator and reset-wake counts keep the run brief. */
`timescale 1ns/1ns
`default_nettype none
module spc_sleep_ctrl_test
    import spc_pkg::*;
;
    localparam int OSC = 8;
    localparam int RST = 16;
    logic clk = 1'b0, nrst = 1'b0, clkEn = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, doSleep = 1'b0, sleepReset = 1'b0, adcEnabled = 1'b0;
    logic compUsesRef = 1'b0, pready, pslverr, err, sleepInstr, cpuHalt, wakeToReset;
    logic cpuClkRun, flashClkRun, ioClkRun, adcClkRun, oscRun, adcStartConv;
    logic adcExtendedConv, bodEnable, compDisable, inBufEnable;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, st;
    logic [5:0]  wakeSel = 6'h00, irq;
    logic [3:0]  moduleClkRun, moduleAccessOk;
    int          badCount = 0, nTests = 0, c;
    assign st = {24'h0, cpuHalt, bodEnable, inBufEnable, cpuClkRun, flashClkRun,
                 ioClkRun, adcClkRun, oscRun};
    spc_sleep_ctrl #(.OSC_START(OSC), .RESET_WAKE(RST)) u_spc_sleep_ctrl (.*,
        .irqPending(irq[5]), .irqPinChange(irq[4]), .irqExtZero(irq[3]),
        .irqMemReady(irq[2]), .irqAdcDone(irq[1]), .irqWatchdog(irq[0]));
    spc_cpu_model u_spc_cpu_model (.*);
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        nTests++;
        if (g !== e)
        begin
            badCount++;
            $display("MISMATCH %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    // Keep set: next setup follows at once, as the unlock window needs
    task automatic apb(input logic w, input logic k, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
        if (!k)
        begin
            psel <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic slp;
        doSleep <= 1'b1;
        @(posedge clk);
        doSleep <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic poke(input logic [5:0] s, input int n);
        wakeSel <= s;
        @(posedge clk);
        wakeSel <= 6'h00;
        repeat (n) @(posedge clk);
    endtask
    // Called as the source level appears: skip model edge and wake edge, then count
    task automatic hw;
        c = 0;
        repeat (2) @(posedge clk);
        while (cpuHalt === 1'b1 && c < 99)
        begin
            c++;
            @(posedge clk);
        end
    endtask
    task automatic fin(input string s);
        $display("test %s done", s);
    endtask
    task automatic finishTest;
        $display("checks %0d, mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (4000) @(posedge clk);
        badCount++;
        $display("MISMATCH %0t: watchdog", $time);
        finishTest;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(st, 32'h7F);
        apb(1'b0, 1'b0, ADDR_CORE_CTRL, 32'h0);
        chk(rd, 32'h0);
        slp;
        chk(st, 32'h7F);
        apb(1'b1, 1'b0, ADDR_CORE_CTRL, 32'h38);
        slp;
        chk(st, 32'h7F);
        fin("entry");
        adcEnabled <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(adcExtendedConv), 32'h1);
        apb(1'b1, 1'b0, ADDR_CORE_CTRL, 32'h20);
        slp;
        chk(st, 32'hE7);
        poke(6'h20, 0);
        hw;
        chk(st, 32'h7F);
        chk(32'(adcExtendedConv), 32'h0);
        apb(1'b1, 1'b0, ADDR_CORE_CTRL, 32'h28);
        slp;
        chk(st, 32'hE3);
        poke(6'h28, 20);
        chk(st, 32'hE3);
        poke(6'h02, 0);
        hw;
        chk(32'(c), 32'(OSC + 4));
        fin("light");
        apb(1'b1, 1'b0, ADDR_WAKE_CFG, 32'h1);
        apb(1'b1, 1'b0, ADDR_CORE_CTRL, 32'h30);
        slp;
        chk(st, 32'hC0);
        chk(32'(compDisable), 32'h1);
        poke(6'h24, 20);
        chk(st, 32'hC0);
        poke(6'h08, 0);
        hw;
        chk(32'(c), 32'(OSC + 4));
        fin("powerdown");
        apb(1'b1, 1'b0, ADDR_CORE_CTRL, 32'h80);
        apb(1'b0, 1'b0, ADDR_CORE_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 1'b0, ADDR_CORE_CTRL, 32'h84);
        repeat (4) @(posedge clk);
        apb(1'b1, 1'b0, ADDR_CORE_CTRL, 32'h80);
        apb(1'b0, 1'b0, ADDR_CORE_CTRL, 32'h0);
        chk(rd, 32'h0);
        compUsesRef <= 1'b1;
        apb(1'b1, 1'b1, ADDR_CORE_CTRL, 32'h84);
        apb(1'b1, 1'b0, ADDR_CORE_CTRL, 32'hB0);
        slp;
        chk(st, 32'h80);
        chk(32'(compDisable), 32'h0);
        poke(6'h10, 0);
        hw;
        chk(32'(c), 32'(RST + 4));
        chk(st, 32'h7F);
        apb(1'b0, 1'b0, ADDR_CORE_CTRL, 32'h0);
        chk(rd & 32'h80, 32'h0);
        fin("brownout");
        apb(1'b1, 1'b0, ADDR_CORE_CTRL, 32'h30);
        slp;
        sleepReset <= 1'b1;
        c = 0;
        while (wakeToReset !== 1'b1 && c < 20)
        begin
            @(posedge clk);
            c++;
        end
        chk(32'(wakeToReset), 32'h1);
        chk(st, 32'h7F);
        sleepReset <= 1'b0;
        fin("reset");
        apb(1'b1, 1'b0, ADDR_CLK_STOP, 32'h1F);
        apb(1'b0, 1'b0, ADDR_CLK_STOP, 32'h0);
        chk(rd, 32'h0F);
        chk({24'h0, moduleClkRun, moduleAccessOk}, 32'h0);
        apb(1'b1, 1'b0, ADDR_CLK_STOP, 32'h0);
        chk({24'h0, moduleClkRun, moduleAccessOk}, 32'hFF);
        apb(1'b0, 1'b0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        fin("clockstop");
        finishTest;
    end
endmodule
bind spc_sleep_ctrl spc_sleep_ctrl_asserts u_spc_sleep_ctrl_asserts (.*);
`default_nettype wire
